/* hw/iurls_link.sv */
// link-state controller of an isolated USB repeater, low and full speed
// assumes line states already sampled synchronous to clk
`timescale 1ns/1ns
module iurls_link
  import iurls_pkg::*;
#(
  parameter int PWRUP_LIM = PWRUP_CYC,
  parameter int SUSP_LIM = SUSP_CYC,
  parameter int WAKE_L2_LIM = WAKE_L2_CYC,
  parameter int DRSM_LIM = DRSM_CYC,
  parameter int RSM_L2_LIM = RSM_L2_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // supplies and line states
  input wire logic supply_ok,
  input wire logic [1:0] upstream_data_lines,
  input wire logic [1:0] downstream_data_lines,
  input wire logic l1_entry,
  // status out
  output logic ready,
  output logic attached,
  output logic disconnect_pulse,
  output logic bus_reset_pulse,
  output logic low_current,
  output iurls_state_t link_state,
  // resume drive
  output logic drive_resume_up,
  output logic drive_resume_down
);
  iurls_state_t state_r, state_nxt;
  logic [CNT_W-1:0] pwr_cnt_r, drsm_cnt_r;
  logic pwr_done, conn_hit, disc_hit, rst_hit, idle_hit;
  logic rsm_l1_hit, rsm_l2_hit, wake_l1_hit, wake_l2_hit;
  logic drsm_done;

  // ****************************************
  // power-up readiness
  // ****************************************
  // counter restarts while supplies are not valid [RULE_01]
  always_ff @(posedge clk) begin
    if (!rstn || !supply_ok) begin
      pwr_cnt_r <= '0;
    end else if (!pwr_done) begin
      pwr_cnt_r <= pwr_cnt_r + 1'b1;
    end
  end
  assign pwr_done = (pwr_cnt_r == PWRUP_LIM[CNT_W-1:0]);

  // ****************************************
  // line filters
  // ****************************************
  localparam int NF = 8;
  localparam int LIM [NF] = '{CONN_CYC, DISC_CYC, RST_CYC, SUSP_LIM, RSM_L1_CYC,
                              RSM_L2_LIM, WAKE_L1_CYC, WAKE_L2_LIM};
  logic [NF-1:0] cond, hit;
  assign cond[0] = (state_r == IURLS_DETACHED) && (downstream_data_lines != LINE_SE0);
  assign cond[1] = (state_r == IURLS_L0) && (downstream_data_lines == LINE_SE0);
  assign cond[2] = (state_r == IURLS_L0) && (upstream_data_lines == LINE_SE0);
  assign cond[3] = (state_r == IURLS_L0) && (upstream_data_lines == LINE_J)
                   && (downstream_data_lines == LINE_J);
  assign cond[4] = (state_r == IURLS_L1) && (upstream_data_lines == LINE_K);
  assign cond[5] = (state_r == IURLS_L2) && (upstream_data_lines == LINE_K);
  assign cond[6] = (state_r == IURLS_L1) && (downstream_data_lines == LINE_K);
  assign cond[7] = (state_r == IURLS_L2) && (downstream_data_lines == LINE_K);
  genvar gi;
  generate
    for (gi = 0; gi < NF; gi++) begin : g_filt
      iurls_filter #(.LIMIT(LIM[gi])) u_filt (
        .clk(clk),
        .rstn(rstn),
        .cond(cond[gi]),
        .hit(hit[gi])
      );
    end
  endgenerate
  assign conn_hit = hit[0];    // [RULE_02]
  assign disc_hit = hit[1];    // [RULE_03]
  assign rst_hit = hit[2];     // [RULE_04]
  assign idle_hit = hit[3];    // [RULE_05]
  assign rsm_l1_hit = hit[4];  // [RULE_06]
  assign rsm_l2_hit = hit[5];  // [RULE_07]
  assign wake_l1_hit = hit[6]; // [RULE_08]
  assign wake_l2_hit = hit[7]; // [RULE_09]

  // ****************************************
  // resume drive timer
  // ****************************************
  // wake in L2 holds resume both ways at least 1 ms [RULE_10]
  always_ff @(posedge clk) begin
    if (!rstn || state_r != IURLS_WAKE) begin
      drsm_cnt_r <= '0;
    end else if (!drsm_done) begin
      drsm_cnt_r <= drsm_cnt_r + 1'b1;
    end
  end
  assign drsm_done = (drsm_cnt_r == DRSM_LIM[CNT_W-1:0]);

  // ****************************************
  // state machine
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      IURLS_POWERUP: if (pwr_done) state_nxt = IURLS_DETACHED;
      IURLS_DETACHED: if (conn_hit) state_nxt = IURLS_L0;
      IURLS_L0: begin
        if (disc_hit) state_nxt = IURLS_DETACHED;
        else if (idle_hit) state_nxt = IURLS_L2;
        else if (l1_entry) state_nxt = IURLS_L1;
      end
      IURLS_L1: if (rsm_l1_hit || wake_l1_hit) state_nxt = IURLS_L0;
      IURLS_L2: begin
        if (wake_l2_hit) state_nxt = IURLS_WAKE;
        else if (rsm_l2_hit) state_nxt = IURLS_L0;
      end
      IURLS_WAKE: if (drsm_done) state_nxt = IURLS_L0;
      default: state_nxt = IURLS_POWERUP;
    endcase
  end
  always_ff @(posedge clk) begin
    if (!rstn || !supply_ok) begin
      state_r <= IURLS_POWERUP;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  logic disc_r, rst_r, rsm_dn_r, rsm_up_r;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      disc_r <= 1'b0;
      rst_r <= 1'b0;
    end else begin
      disc_r <= disc_hit;  // [RULE_03]
      rst_r <= rst_hit;    // [RULE_04]
    end
  end
  // resume mirrored downstream while upstream keeps K [RULE_06] [RULE_07]
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rsm_dn_r <= 1'b0;
      rsm_up_r <= 1'b0;
    end else begin
      rsm_dn_r <= (state_nxt == IURLS_WAKE) || rsm_l1_hit || rsm_l2_hit
                  || (rsm_dn_r && upstream_data_lines == LINE_K && state_nxt == IURLS_L0);
      rsm_up_r <= (state_nxt == IURLS_WAKE) || wake_l1_hit
                  || (rsm_up_r && downstream_data_lines == LINE_K && state_nxt == IURLS_L0);
    end
  end
  assign ready = (state_r != IURLS_POWERUP);
  assign attached = (state_r != IURLS_POWERUP) && (state_r != IURLS_DETACHED);
  assign low_current = (state_r == IURLS_L2); // [RULE_05]
  assign link_state = state_r;
  assign disconnect_pulse = disc_r;
  assign bus_reset_pulse = rst_r;
  assign drive_resume_up = rsm_up_r;
  assign drive_resume_down = rsm_dn_r;

  // ****************************************
  // check helpers
  // ****************************************
  // run lengths counted apart from the filters, so a wrong filter limit shows up
  logic [CNT_W-1:0] conn_run_r, disc_run_r, rst_run_r, hold_run_r;
  always_ff @(posedge clk) begin
    if (!rstn || state_r != IURLS_DETACHED || downstream_data_lines == LINE_SE0) begin
      conn_run_r <= '0;
    end else if (conn_run_r != '1) begin
      conn_run_r <= conn_run_r + 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn || state_r != IURLS_L0 || downstream_data_lines != LINE_SE0) begin
      disc_run_r <= '0;
    end else if (disc_run_r != '1) begin
      disc_run_r <= disc_run_r + 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn || state_r != IURLS_L0 || upstream_data_lines != LINE_SE0) begin
      rst_run_r <= '0;
    end else if (rst_run_r != '1) begin
      rst_run_r <= rst_run_r + 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn || !drive_resume_up || !drive_resume_down) begin
      hold_run_r <= '0;
    end else if (hold_run_r != '1) begin
      hold_run_r <= hold_run_r + 1'b1;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_pwrup_ready: assert property ($rose(pwr_done) |=> ready) else $error("ready late"); // [RULE_01]
  a_conn_debounce: assert property ($rose(attached) |-> $past(cond[0], 2)) // [RULE_02]
    else $error("connect unfiltered");
  a_conn_length: assert property ($rose(attached) |-> conn_run_r >= CONN_CYC[CNT_W-1:0]) // [RULE_02]
    else $error("connect too early");
  a_disc_fast: assert property ($rose(disc_hit) |=> disconnect_pulse && state_r == IURLS_DETACHED) // [RULE_03]
    else $error("disconnect missed");
  a_disc_window: assert property ($rose(disconnect_pulse) |-> // [RULE_03]
    disc_run_r >= CNT_W'(DISC_MIN_US * CLK_MHZ) && disc_run_r <= CNT_W'(DISC_MAX_US * CLK_MHZ))
    else $error("disconnect outside window");
  a_rst_window: assert property ($rose(bus_reset_pulse) |-> rst_run_r <= CNT_W'(RST_MAX_US * CLK_MHZ)) // [RULE_04]
    else $error("reset late");
  a_rst_pulse: assert property (rst_hit |=> bus_reset_pulse) else $error("reset missed"); // [RULE_04]
  a_susp_lowi: assert property (idle_hit && !disc_hit |=> low_current) else $error("no suspend"); // [RULE_05]
  a_rsm_l1_drv: assert property (rsm_l1_hit |=> drive_resume_down) else $error("L1 resume lost"); // [RULE_06]
  a_rsm_l2_drv: assert property (rsm_l2_hit && !wake_l2_hit |=> drive_resume_down) // [RULE_07]
    else $error("L2 resume lost");
  a_wake_l1_prop: assert property (wake_l1_hit |=> drive_resume_up) else $error("L1 wake lost"); // [RULE_08]
  a_wake_hold: assert property ($rose(state_r == IURLS_WAKE) && supply_ok // [RULE_10]
    |-> ##1 (drive_resume_up && drive_resume_down) [*8]) else $error("wake resume short");
  a_wake_length: assert property (state_r == IURLS_L0 && $past(state_r) == IURLS_WAKE // [RULE_10]
    |-> hold_run_r > DRSM_LIM[CNT_W-1:0]) else $error("wake resume ended early");
  c_attach: cover property ($rose(attached));
  c_disconnect: cover property ($rose(disconnect_pulse));
  c_l1_resume: cover property (state_r == IURLS_L1 ##1 state_r == IURLS_L0);
  c_suspend: cover property ($rose(low_current));
  c_wake: cover property (state_r == IURLS_WAKE ##1 state_r == IURLS_L0);
endmodule

/* inc/iurls_pkg.sv */
// constants, types and timing counts for the repeater link-state controller
// assumes a 125 MHz clock; all times are turned into whole clock cycles here
// Summary of operation
// [RULE_01] ready and sensing within 10 ms
// [RULE_02] connect accepted after 45-80 us debounce
// [RULE_03] downstream disconnect detected within 2-7 us
// [RULE_04] upstream bus reset detected within 7 us
// [RULE_05] idle 3-10 ms enters suspend, low current
// [RULE_06] L1 upstream resume reaches downstream within 1 us
// [RULE_07] L2 upstream resume reaches downstream within 130 us
// [RULE_08] L1 remote wake propagated within 5 us
// [RULE_09] L2 remote wake must last 900 us; the L2 wake filter accepts it after 450 us
// [RULE_10] L2 wake drives resume both ways 1 ms
// [RULE_11] windows are local-clock counters restarting on change
package iurls_pkg;
  localparam int CLK_MHZ = 125;
  // times as printed, in their own units
  localparam int PWRUP_TYP_MS = 5;
  localparam int CONN_TYP_US = 70;
  localparam int DISC_MIN_US = 2;
  localparam int DISC_MAX_US = 7;
  localparam int RST_MAX_US = 7;
  localparam int SUSP_MIN_MS = 3;
  localparam int SUSP_MAX_MS = 10;
  localparam int RSM_L1_MAX_US = 1;
  localparam int RSM_L2_MAX_US = 130;
  localparam int WAKE_L1_MAX_US = 5;
  localparam int WAKE_L2_US = 900;
  localparam int DRSM_MIN_MS = 1;
  // cycle counts; filters sit mid-window to tolerate clock drift, except connect at its typical time and L1 resume at a quarter
  localparam int PWRUP_CYC = PWRUP_TYP_MS * 1000 * CLK_MHZ;
  localparam int CONN_CYC = CONN_TYP_US * CLK_MHZ;
  localparam int DISC_CYC = (DISC_MIN_US + DISC_MAX_US) * CLK_MHZ / 2;
  localparam int RST_CYC = RST_MAX_US * CLK_MHZ / 2;
  localparam int SUSP_CYC = (SUSP_MIN_MS + SUSP_MAX_MS) * 1000 * CLK_MHZ / 2;
  localparam int RSM_L1_CYC = RSM_L1_MAX_US * CLK_MHZ / 4;
  localparam int RSM_L2_CYC = RSM_L2_MAX_US * CLK_MHZ / 2;
  localparam int WAKE_L1_CYC = WAKE_L1_MAX_US * CLK_MHZ / 2;
  localparam int WAKE_L2_CYC = WAKE_L2_US * CLK_MHZ / 2;
  localparam int DRSM_CYC = DRSM_MIN_MS * 1000 * CLK_MHZ + 16;
  localparam int CNT_W = 24;
  // bus line states as seen on a port
  localparam logic [1:0] LINE_SE0 = 2'h0;
  localparam logic [1:0] LINE_J = 2'h1;
  localparam logic [1:0] LINE_K = 2'h2;
  typedef enum logic [2:0] {
    IURLS_POWERUP, IURLS_DETACHED, IURLS_L0, IURLS_L1, IURLS_L2, IURLS_WAKE
  } iurls_state_t;
endpackage

/* hw/iurls_filter.sv */
// stable-level filter: pulses once a condition has held for LIMIT cycles
// assumes cond is synchronous to clk
`timescale 1ns/1ns
module iurls_filter
  import iurls_pkg::*;
#(
  parameter int LIMIT = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // condition in, hit out
  input wire logic cond,
  output logic hit
);
  logic [CNT_W-1:0] cnt_r;
  // restart whenever the condition drops [RULE_11]
  always_ff @(posedge clk) begin
    if (!rstn || !cond) begin
      cnt_r <= '0;
    end else if (cnt_r != LIMIT[CNT_W-1:0]) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
  assign hit = cond && (cnt_r == LIMIT[CNT_W-1:0] - 1'b1);
endmodule

/* tb/iurls_partner.sv */
// far-side model: host upstream, peripheral downstream
// assumes the bench steers line requests on clk
`timescale 1ns/1ns
module iurls_partner
  import iurls_pkg::*;
#(
  parameter int WAKE_HOLD = 400
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // bench requests
  input wire logic [1:0] up_req,
  input wire logic [1:0] dn_req,
  input wire logic wake_req,
  // line states
  output logic [1:0] upstream_data_lines,
  output logic [1:0] downstream_data_lines
);
  int wake_cnt_r;
  // wake held past the l2 detect time
  always_ff @(posedge clk) begin
    if (!rstn) wake_cnt_r <= 0;
    else if (wake_req) wake_cnt_r <= WAKE_HOLD;
    else if (wake_cnt_r > 0) wake_cnt_r <= wake_cnt_r - 1;
  end
  // detached peripheral: pull-downs give se0
  assign upstream_data_lines = up_req;
  assign downstream_data_lines = (wake_cnt_r > 0) ? LINE_K : dn_req;
endmodule

/* tb/test_isolated_usb_repeater_link_state.sv */
// bench for the link-state controller, short long-count parameters
// assumes the partner model drives both ports
`timescale 1ns/1ns
module test_isolated_usb_repeater_link_state
  import iurls_pkg::*;
;
  localparam int PW = 20;
  localparam int SU = 50;
  localparam int WK = 40;
  localparam int DR = 30;
  localparam int R2 = 10;
  logic clk, rstn, supply_ok, l1_entry, wake_req;
  logic [1:0] up_req, dn_req, up_l, dn_l;
  logic ready, attached, disconnect_pulse, bus_reset_pulse, low_current;
  logic drive_resume_up, drive_resume_down;
  iurls_state_t link_state;
  int fail_count, compares;
  iurls_partner #(.WAKE_HOLD(400)) far_end (.clk(clk), .rstn(rstn), .up_req(up_req), .dn_req(dn_req),
    .wake_req(wake_req), .upstream_data_lines(up_l), .downstream_data_lines(dn_l));
  iurls_link #(.PWRUP_LIM(PW), .SUSP_LIM(SU), .WAKE_L2_LIM(WK), .DRSM_LIM(DR), .RSM_L2_LIM(R2)) DUT (
    .clk(clk), .rstn(rstn), .supply_ok(supply_ok), .upstream_data_lines(up_l),
    .downstream_data_lines(dn_l), .l1_entry(l1_entry), .ready(ready), .attached(attached),
    .disconnect_pulse(disconnect_pulse), .bus_reset_pulse(bus_reset_pulse), .low_current(low_current),
    .link_state(link_state), .drive_resume_up(drive_resume_up), .drive_resume_down(drive_resume_down));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ******
  // shared tasks
  // ******
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function automatic logic pick(int k);
    case (k)
      0: return ready;
      1: return attached;
      2: return disconnect_pulse;
      3: return bus_reset_pulse;
      4: return low_current;
      5: return drive_resume_up;
      default: return drive_resume_down;
    endcase
  endfunction
  // counts cycles to an output; a small slack covers filter pipelining
  task automatic await(string what, int k, int lim);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (pick(k) !== 1'b1 && n < lim + 300);
    chk(what, 32'(n >= lim - 2 && n <= lim + 4), 32'h1);
    if (n >= lim + 300) conclude();
  endtask
  task automatic edge_set(logic [1:0] u, logic [1:0] d);
    @(posedge clk);
    up_req <= u;
    dn_req <= d;
  endtask
  // ******
  // scenarios
  // ******
  task automatic t_power();
    #1;
    chk("ready", ready, 1'b0);
    @(posedge clk);
    supply_ok <= 1'b1;
    await("ready", 0, PW);
    chk("state", link_state, IURLS_DETACHED);
    $display("power-up done");
  endtask
  task automatic t_connect();
    edge_set(LINE_K, LINE_J);
    repeat (4000) @(posedge clk);
    dn_req <= LINE_SE0;
    edge_set(LINE_K, LINE_J);
    await("attach", 1, CONN_CYC);
    chk("state", link_state, IURLS_L0);
    $display("connect done");
  endtask
  task automatic t_reset_disc();
    edge_set(LINE_SE0, LINE_J);
    await("reset", 3, RST_CYC);
    chk("state", link_state, IURLS_L0);
    edge_set(LINE_K, LINE_SE0);
    await("disc", 2, DISC_CYC);
    #8;
    chk("state", link_state, IURLS_DETACHED);
    $display("reset and disconnect done");
  endtask
  task automatic t_l1();
    edge_set(LINE_J, LINE_J);
    l1_entry <= 1'b1;
    @(posedge clk);
    l1_entry <= 1'b0;
    #1;
    chk("state", link_state, IURLS_L1);
    edge_set(LINE_K, LINE_J);
    await("resume", 6, RSM_L1_CYC);
    edge_set(LINE_J, LINE_J);
    repeat (4) @(posedge clk);
    l1_entry <= 1'b1;
    @(posedge clk);
    l1_entry <= 1'b0;
    wake_req <= 1'b1;
    @(posedge clk);
    wake_req <= 1'b0;
    await("wake", 5, WAKE_L1_CYC);
    $display("l1 done");
  endtask
  // idle counting restarts once the downstream wake has ended
  task automatic t_susp();
    int n;
    n = 0;
    edge_set(LINE_J, LINE_J);
    while (dn_l !== LINE_J && n < 1000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("wake end", 32'(n < 1000), 32'h1);
    if (n >= 1000) conclude();
    await("suspend", 4, SU);
    chk("state", link_state, IURLS_L2);
  endtask
  task automatic t_l2();
    int n;
    t_susp();
    @(posedge clk);
    wake_req <= 1'b1;
    @(posedge clk);
    wake_req <= 1'b0;
    await("wake", 5, WK);
    chk("resume down", drive_resume_down, 1'b1);
    n = 1;
    while (drive_resume_up === 1'b1 && drive_resume_down === 1'b1 && n < DR + 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("hold", 32'(n >= DR && n < DR + 100), 32'h1);
    if (n >= DR + 100) conclude();
    t_susp();
    edge_set(LINE_K, LINE_J);
    await("resume", 6, R2);
    $display("l2 done");
  endtask
  initial begin
    rstn = 1'b0;
    supply_ok = 1'b0;
    l1_entry = 1'b0;
    wake_req = 1'b0;
    up_req = LINE_SE0;
    dn_req = LINE_SE0;
    fail_count = 0;
    compares = 0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    t_power();
    t_connect();
    t_reset_disc();
    t_connect();
    t_l1();
    t_l2();
    conclude();
  end
endmodule
